// File: design/error_log_pkg.sv
// How it works
// RULE1: Capture sticky read-only 128-bit log on error
// RULE2: Log bits 127 to 90 read zero
// RULE3: Bit 89 zero master, one completer abort
// RULE4: Message code sits in bits 88 to 81
// RULE5: Interrupt data sits in bits 80 to 65
// RULE6: Switch route id sits in bits 64 to 58
// RULE7: Format, type bits 57-51; address 50-0
// RULE8: Route id kept apart from requester id
// RULE9: Upper route bits decode the source group
// RULE10: DMA lower codes: fetch, copy, XOR access
// RULE11: Code 0110/000 coherent link; 0111+ reserved
// RULE12: Load first error only; survive warm reset
package error_log_pkg;
   // Configuration space placement of the log
   localparam logic [11:0] LOG_OFS      = 12'h3a4;
   localparam logic [11:0] LOG_LAST_OFS = 12'h3b0;
   localparam int          LOG_W        = 128;
   // Field positions inside the log
   localparam int RSV_HI   = 127;
   localparam int RSV_LO   = 90;
   localparam int ETYPE_B  = 89;
   localparam int MSG_HI   = 88;
   localparam int MSG_LO   = 81;
   localparam int MSI_HI   = 80;
   localparam int MSI_LO   = 65;
   localparam int ROUTE_HI = 64;
   localparam int ROUTE_LO = 58;
   localparam int FT_HI    = 57;
   localparam int FT_LO    = 51;
   localparam int ADDR_HI  = 50;
   // Values after reset
   localparam logic [LOG_W-1:0] LOG_RST = 128'h0;
   localparam logic [31:0]      RD_RST  = 32'h0;
   // Error type encoding
   localparam logic MASTER_ABORT_TYPE    = 1'b0;
   localparam logic COMPLETER_ABORT_TYPE = 1'b1;
   // Upper route id codes
   localparam logic [3:0] GRP_ROOT_PORTS = 4'h0;
   localparam logic [3:0] GRP_PLAT_HUB   = 4'h2;
   localparam logic [3:0] GRP_DMA        = 4'h3;
   localparam logic [3:0] GRP_MISC       = 4'h5;
   localparam logic [3:0] GRP_COH_LINK   = 4'h6;
   // Lower route id codes
   localparam logic [2:0] ROOT_LAST_SUB  = 3'h3;
   localparam logic [2:0] DMA_FETCH_RFO  = 3'h0;
   localparam logic [2:0] DMA_MEM_IO     = 3'h1;
   localparam logic [2:0] DMA_XOR_DESC   = 3'h2;
   localparam logic [2:0] COH_LINK_SUB   = 3'h0;

   typedef enum logic [2:0] {
      SRC_ROOT_PORT, SRC_PLATFORM_HUB, SRC_DMA, SRC_MISC,
      SRC_COHERENT_LINK, SRC_RESERVED
   } src_class_t;

   typedef enum logic [1:0] {
      DMA_OP_NONE, DMA_OP_FETCH_RFO, DMA_OP_MEM_IO, DMA_OP_XOR
   } dma_op_t;
endpackage

// File: design/route_if.sv
`timescale 1ns/10ps
`default_nettype none
// Carries a switch route id to its decoder and the verdict back
interface route_if;
   import error_log_pkg::*;
   logic [6:0] route_id;
   src_class_t src_class;
   dma_op_t    dma_op;
   logic       reserved;
   modport decoder (input route_id, output src_class, dma_op, reserved);
   modport user    (output route_id, input src_class, dma_op, reserved);
endinterface
`default_nettype wire

// File: design/route_decode.sv
`timescale 1ns/10ps
`default_nettype none
module route_decode
   import error_log_pkg::*;
(
   route_if.decoder rif
);
   logic [3:0] grp;
   logic [2:0] sub;
   assign grp = rif.route_id[6:3];
   assign sub = rif.route_id[2:0];

   // Classify the source group and its subcode
   always_comb begin
      rif.src_class = SRC_RESERVED;
      rif.dma_op    = DMA_OP_NONE;
      rif.reserved  = 1'b1;
      unique case (grp)
         GRP_ROOT_PORTS: begin
            if (sub <= ROOT_LAST_SUB) begin // see RULE9
               rif.src_class = SRC_ROOT_PORT;
               rif.reserved  = 1'b0;
            end
         end
         GRP_PLAT_HUB: begin
            rif.src_class = SRC_PLATFORM_HUB; // see RULE9
            rif.reserved  = 1'b0;
         end
         GRP_DMA: begin
            rif.src_class = SRC_DMA; // see RULE9
            rif.reserved  = 1'b0;
            unique case (sub)
               DMA_FETCH_RFO: rif.dma_op = DMA_OP_FETCH_RFO; // see RULE10
               DMA_MEM_IO:    rif.dma_op = DMA_OP_MEM_IO; // see RULE10
               DMA_XOR_DESC:  rif.dma_op = DMA_OP_XOR; // see RULE10
               default:       rif.reserved = 1'b1;
            endcase
         end
         GRP_MISC: begin
            rif.src_class = SRC_MISC; // see RULE9
            rif.reserved  = 1'b0;
         end
         GRP_COH_LINK: begin
            if (sub == COH_LINK_SUB) begin // see RULE11
               rif.src_class = SRC_COHERENT_LINK;
               rif.reserved  = 1'b0;
            end
         end
         default: begin
            rif.src_class = SRC_RESERVED; // see RULE11
            rif.reserved  = 1'b1;
         end
      endcase
   end
endmodule
`default_nettype wire

// File: design/error_header_log.sv
`timescale 1ns/10ps
`default_nettype none
module error_header_log
   import error_log_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        warm_reset_n,
   // Error report from the data path
   input  wire logic        err_valid,
   input  wire logic        err_completer_abort,
   input  wire logic [7:0]  err_msg_code,
   input  wire logic [15:0] err_msi_data,
   input  wire logic [6:0]  err_route_id,
   input  wire logic [1:0]  err_fmt,
   input  wire logic [4:0]  err_type,
   input  wire logic [50:0] err_addr,
   input  wire logic        log_rearm,
   // Configuration read port
   input  wire logic        cfg_rd,
   input  wire logic [11:0] cfg_addr,
   output logic             cfg_rd_valid_q,
   output logic [31:0]      cfg_rd_data_q,
   // Captured state
   output logic             log_held_q,
   output src_class_t       src_class_q,
   output dma_op_t          dma_op_q,
   output logic             route_reserved_q
);
   logic             rst_meta_q;
   logic             rst_n_q;
   logic             warm_meta_q;
   logic             warm_n_q;
   logic [LOG_W-1:0] log_q;
   logic [LOG_W-1:0] log_d;
   logic             capture;
   logic             in_range;
   logic [11:0]      rel_ofs;
   logic [1:0]       word_idx;
   route_if          rif ();

   // Release the power-on reset through two flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Warm reset pin passes two flops before use
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         warm_meta_q <= 1'b0;
         warm_n_q    <= 1'b0;
      end else begin
         warm_meta_q <= warm_reset_n;
         warm_n_q    <= warm_meta_q;
      end
   end

   // Decode the route id of the incoming error
   assign rif.route_id = err_route_id;
   route_decode u_route_decode (
      .rif (rif.decoder)
   );

   // Pack the header; upper bits stay zero
   assign log_d = {{(RSV_HI-RSV_LO+1){1'b0}}, // see RULE2
                   err_completer_abort, // see RULE3
                   err_msg_code, // see RULE4
                   err_msi_data, // see RULE5
                   err_route_id, // see RULE6, RULE8
                   err_fmt, err_type, err_addr}; // see RULE7

   // Only the first error after arming is taken
   assign capture = err_valid && !log_held_q; // see RULE12

   // Sticky log, untouched by warm reset
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         log_q <= LOG_RST;
      end else if (capture) begin
         log_q <= log_d; // see RULE1
      end
   end

   // Held flag; while held, a rearm beats a new error
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         log_held_q <= 1'b0;
      end else if (capture) begin
         log_held_q <= 1'b1; // see RULE12
      end else if (log_rearm) begin
         log_held_q <= 1'b0;
      end
   end

   // Source class captured with the log
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         src_class_q      <= SRC_ROOT_PORT;
         dma_op_q         <= DMA_OP_NONE;
         route_reserved_q <= 1'b0;
      end else if (capture) begin
         src_class_q      <= rif.src_class; // see RULE9
         dma_op_q         <= rif.dma_op; // see RULE10
         route_reserved_q <= rif.reserved; // see RULE11
      end
   end

   // Word select for configuration reads
   assign rel_ofs  = cfg_addr - LOG_OFS;
   assign in_range = (cfg_addr[11:2] >= LOG_OFS[11:2])
                     && (cfg_addr[11:2] <= LOG_LAST_OFS[11:2]);
   assign word_idx = rel_ofs[3:2];

   // Read-only answer one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_rd_valid_q <= 1'b0;
         cfg_rd_data_q  <= RD_RST;
      end else if (!warm_n_q) begin
         cfg_rd_valid_q <= 1'b0;
         cfg_rd_data_q  <= RD_RST;
      end else begin
         cfg_rd_valid_q <= cfg_rd;
         if (cfg_rd && in_range) begin
            cfg_rd_data_q <= log_q[32*word_idx +: 32]; // see RULE1
         end else if (cfg_rd) begin
            cfg_rd_data_q <= RD_RST;
         end
      end
   end

   // Checks on the log and its read port
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_q);

   sequence rd_req_s;
      cfg_rd && warm_n_q;
   endsequence
   sequence rd_ans_s;
      cfg_rd_valid_q ##1 !cfg_rd_valid_q;
   endsequence

   read_answer_a: assert property ( // see RULE1
      rd_req_s ##1 !cfg_rd |-> rd_ans_s)
      else $error("Read answer not one cycle late");
   read_word0_a: assert property ( // see RULE1
      (rd_req_s and (cfg_addr == LOG_OFS))
      |=> cfg_rd_data_q == $past(log_q[31:0]))
      else $error("Read data differs from low log word");
   reserved_zero_a: assert property ( // see RULE2
      log_q[RSV_HI:RSV_LO] == 38'h0)
      else $error("Reserved log bits not zero");
   error_type_a: assert property ( // see RULE3
      capture |=> log_q[ETYPE_B] == $past(err_completer_abort))
      else $error("Error type bit wrong");
   msg_code_a: assert property ( // see RULE4
      capture |=> log_q[MSG_HI:MSG_LO] == $past(err_msg_code))
      else $error("Message code field wrong");
   msi_data_a: assert property ( // see RULE5
      capture |=> log_q[MSI_HI:MSI_LO] == $past(err_msi_data))
      else $error("Interrupt data field wrong");
   route_field_a: assert property ( // see RULE6
      capture |=> log_q[ROUTE_HI:ROUTE_LO] == $past(err_route_id))
      else $error("Route id field wrong");
   fmt_addr_a: assert property ( // see RULE7
      capture |=> log_q[FT_HI:0] == $past({err_fmt, err_type, err_addr}))
      else $error("Format, type or address field wrong");
   first_only_a: assert property ( // see RULE12
      log_held_q && !log_rearm |=> log_held_q && $stable(log_q))
      else $error("Held log changed");
   dma_group_a: assert property ( // see RULE9
      capture && err_route_id[6:3] == GRP_DMA |=> src_class_q == SRC_DMA)
      else $error("DMA group not classified");
   dma_xor_a: assert property ( // see RULE10
      capture && err_route_id == {GRP_DMA, DMA_XOR_DESC}
      |=> dma_op_q == DMA_OP_XOR && !route_reserved_q)
      else $error("DMA XOR access not classified");
   coh_link_a: assert property ( // see RULE11
      capture && err_route_id[6:3] == GRP_COH_LINK
      |=> (src_class_q == SRC_COHERENT_LINK)
          == ($past(err_route_id[2:0]) == COH_LINK_SUB))
      else $error("Coherent link code misclassified");

   // Held flag follows capture and rearm
   held_set_a: assert property ( // see RULE12
      capture |=> log_held_q)
      else $error("Held flag not set by capture");
   rearm_clear_a: assert property ( // see RULE12
      log_held_q && log_rearm |=> !log_held_q)
      else $error("Rearm did not clear held flag");

   // Read port quiet in warm reset; unmapped reads give zero
   warm_quiet_a: assert property ( // see RULE12
      !warm_n_q |=> !cfg_rd_valid_q && cfg_rd_data_q == RD_RST)
      else $error("Read port active during warm reset");
   read_word3_a: assert property ( // see RULE2
      (rd_req_s and (cfg_addr == LOG_LAST_OFS))
      |=> cfg_rd_data_q == $past(log_q[127:96]))
      else $error("Read data differs from top log word");
   unmapped_zero_a: assert property ( // see RULE1
      (rd_req_s and (cfg_addr > LOG_LAST_OFS + 12'h003))
      |=> cfg_rd_valid_q && cfg_rd_data_q == RD_RST)
      else $error("Unmapped read not zero");

   // Remaining source groups and reserved codes
   root_port_a: assert property ( // see RULE9
      capture && err_route_id[6:3] == GRP_ROOT_PORTS
      |=> (src_class_q == SRC_ROOT_PORT)
          == ($past(err_route_id[2:0]) <= ROOT_LAST_SUB))
      else $error("Root port code misclassified");
   plat_hub_a: assert property ( // see RULE9
      capture && err_route_id[6:3] == GRP_PLAT_HUB
      |=> src_class_q == SRC_PLATFORM_HUB && !route_reserved_q)
      else $error("Platform hub group not classified");
   misc_group_a: assert property ( // see RULE9
      capture && err_route_id[6:3] == GRP_MISC
      |=> src_class_q == SRC_MISC && !route_reserved_q)
      else $error("Miscellaneous group not classified");
   dma_bad_sub_a: assert property ( // see RULE10
      capture && err_route_id[6:3] == GRP_DMA
      && err_route_id[2:0] > DMA_XOR_DESC
      |=> src_class_q == SRC_DMA && route_reserved_q)
      else $error("Reserved DMA subcode not flagged");
   upper_reserved_a: assert property ( // see RULE11
      capture && err_route_id[6:3] > GRP_COH_LINK
      |=> src_class_q == SRC_RESERVED && route_reserved_q)
      else $error("Reserved upper route code not flagged");
endmodule
`default_nettype wire

// File: verif/error_header_log_test.sv
`timescale 1ns/10ps
`default_nettype none
// Compare one value, count it, report a mismatch at once
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
   n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module error_header_log_test;
   import error_log_pkg::*;
   typedef struct packed {
      logic [6:0] r;
      src_class_t c;
      dma_op_t    o;
      logic       v;
   } row_t;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        warm_reset_n = 1'b1;
   logic        err_valid = 1'b0;
   logic        err_ca = 1'b0;
   logic [7:0]  err_msg = 8'h00;
   logic [15:0] err_msi = 16'h0000;
   logic [6:0]  err_route = 7'h00;
   logic [1:0]  err_fmt = 2'h0;
   logic [4:0]  err_type = 5'h00;
   logic [50:0] err_addr = '0;
   logic        log_rearm = 1'b0;
   logic        cfg_rd = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic        rd_valid;
   logic [31:0] rd_data;
   logic        held;
   src_class_t  cls;
   dma_op_t     op;
   logic        rsv;
   logic [127:0] exp_log;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;
   // Route codes beside the decode they should give
   row_t rows [13] = '{
      '{7'h00, SRC_ROOT_PORT, DMA_OP_NONE, 1'b0},
      '{7'h03, SRC_ROOT_PORT, DMA_OP_NONE, 1'b0},
      '{7'h04, SRC_RESERVED, DMA_OP_NONE, 1'b1},
      '{7'h15, SRC_PLATFORM_HUB, DMA_OP_NONE, 1'b0},
      '{7'h18, SRC_DMA, DMA_OP_FETCH_RFO, 1'b0},
      '{7'h19, SRC_DMA, DMA_OP_MEM_IO, 1'b0},
      '{7'h1a, SRC_DMA, DMA_OP_XOR, 1'b0},
      '{7'h1b, SRC_DMA, DMA_OP_NONE, 1'b1},
      '{7'h2f, SRC_MISC, DMA_OP_NONE, 1'b0},
      '{7'h30, SRC_COHERENT_LINK, DMA_OP_NONE, 1'b0},
      '{7'h31, SRC_RESERVED, DMA_OP_NONE, 1'b1},
      '{7'h08, SRC_RESERVED, DMA_OP_NONE, 1'b1},
      '{7'h7f, SRC_RESERVED, DMA_OP_NONE, 1'b1}};

   error_header_log DUT (.clk_sys(clk_sys), .reset_n(reset_n),
      .warm_reset_n(warm_reset_n), .err_valid(err_valid),
      .err_completer_abort(err_ca), .err_msg_code(err_msg),
      .err_msi_data(err_msi), .err_route_id(err_route),
      .err_fmt(err_fmt), .err_type(err_type), .err_addr(err_addr),
      .log_rearm(log_rearm), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_rd_valid_q(rd_valid), .cfg_rd_data_q(rd_data),
      .log_held_q(held), .src_class_q(cls), .dma_op_q(op),
      .route_reserved_q(rsv));

   // System clock, 10 ns period
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // Cut a hang short
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One read; answer sampled 1 ns after the edge that takes it
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      @(posedge clk_sys);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk_sys);
      cfg_rd <= 1'b0;
      #1;
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", ex, rd_data)
   endtask

   // Read all four dwords of the log
   task automatic chk_log(input logic [127:0] ex);
      for (int k = 0; k < 4; k++) begin
         rd(LOG_OFS + 12'(4 * k), ex[32 * k +: 32]);
      end
   endtask

   // Report one error with fields made from n, route id from r
   task automatic capt(input int n, input logic [6:0] r);
      @(posedge clk_sys);
      err_valid <= 1'b1;
      err_ca <= n[0];
      err_msg <= 8'(8'h5a ^ n);
      err_msi <= 16'(16'ha5c3 + n);
      err_route <= r;
      err_fmt <= 2'(n);
      err_type <= 5'(5'h1f - n);
      err_addr <= 51'h5_5555_0000_0000 ^ 51'(n);
      @(posedge clk_sys);
      err_valid <= 1'b0;
      #1;
   endtask

   task automatic rearm();
      @(posedge clk_sys);
      log_rearm <= 1'b1;
      @(posedge clk_sys);
      log_rearm <= 1'b0;
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("held", 1'b0, held)
      `CHK("cls", SRC_ROOT_PORT, cls)
      chk_log(LOG_RST);
      foreach (rows[i]) begin
         rearm();
         capt(i, rows[i].r);
         exp_log = {38'h0, i[0], 8'(8'h5a ^ i), 16'(16'ha5c3 + i), rows[i].r,
                    2'(i), 5'(5'h1f - i), 51'h5_5555_0000_0000 ^ 51'(i)};
         `CHK("held", 1'b1, held)
         `CHK("cls", rows[i].c, cls)
         `CHK("op", rows[i].o, op)
         `CHK("rsv", rows[i].v, rsv)
         chk_log(exp_log);
      end
      // A second error while held is ignored
      capt(20, 7'h15);
      `CHK("cls", SRC_RESERVED, cls)
      chk_log(exp_log);
      rd(12'h3b4, 32'h0000_0000);
      rd(LOG_OFS + 12'h004, exp_log[63:32]);
      // Warm reset clears the read port only
      @(posedge clk_sys);
      warm_reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("rd_data", 32'h0000_0000, rd_data)
      `CHK("held", 1'b1, held)
      // A read during warm reset gets no answer
      @(posedge clk_sys);
      cfg_rd <= 1'b1;
      cfg_addr <= LOG_OFS;
      @(posedge clk_sys);
      cfg_rd <= 1'b0;
      #1;
      `CHK("rd_valid", 1'b0, rd_valid)
      @(posedge clk_sys);
      warm_reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk_log(exp_log);
      // Power-on reset in mid-run clears the log
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("held", 1'b0, held)
      `CHK("cls", SRC_ROOT_PORT, cls)
      chk_log(LOG_RST);
      close_out();
   end
endmodule
`default_nettype wire
